/* btd_pkg.sv */
package btd_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [7:0] BTD_CTRL_OFS   = 8'h00;
	localparam logic [7:0] BTD_FREQ_OFS   = 8'h04;
	localparam logic [7:0] BTD_DUTY_OFS   = 8'h08;
	localparam logic [7:0] BTD_PORT_OFS   = 8'h0C;
	localparam logic [7:0] BTD_STATUS_OFS = 8'h10;

	// ==========================================================
	// Field positions
	localparam int BTD_CTRL_GATE_BIT  = 0;
	localparam int BTD_CTRL_OE_BIT    = 1;
	localparam int BTD_PORT_DATA_BIT  = 0;
	localparam int BTD_PORT_DIR_BIT   = 1;
	localparam int BTD_STAT_TONE_BIT  = 0;
	localparam int BTD_STAT_PIN_BIT   = 1;
	localparam int BTD_STAT_OVR_BIT   = 2;
	localparam int BTD_STAT_DUTY_LSB  = 4;
	localparam int BTD_STAT_CNT_LSB   = 8;

	// ==========================================================
	// Reset values
	localparam logic       BTD_GATE_RST     = 1'b0;
	localparam logic       BTD_OE_RST       = 1'b0;
	localparam logic [2:0] BTD_FREQ_RST     = 3'h0;
	localparam logic [2:0] BTD_DUTY_RST     = 3'h0;
	localparam logic       BTD_PORT_DATA_RST = 1'b0;
	localparam logic       BTD_PORT_DIR_RST = 1'b0;

	// ==========================================================
	// Tone timing, period and high time counted in oscillator half cycles
	localparam int         BTD_OSC_FREQ_HZ   = 32768;
	localparam int         BTD_BURST_DIV     = 128;
	localparam logic [6:0] BTD_BURST_LAST    = 7'(BTD_BURST_DIV - 1);
	localparam logic [5:0] BTD_PERIOD_BASE   = 6'h10;
	localparam logic [5:0] BTD_PERIOD_STEP   = 6'h04;
	localparam logic [5:0] BTD_HIGH_BASE_LO  = 6'h08;
	localparam logic [5:0] BTD_HIGH_BASE_HI  = 6'h0C;

endpackage

/* btd_tone_shaper.sv */
`timescale 1ns/100ps

module btd_tone_shaper
	import btd_pkg::*;
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Control
	input  wire logic       run,
	input  wire logic       half_tick,
	input  wire logic [2:0] freq_sel,
	input  wire logic [2:0] duty_sel,
	// Tone
	output logic            tone_level,
	output logic [5:0]      half_count
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [5:0] cnt;
		logic       level;
	} btd_shaper_t;

	btd_shaper_t st_reg;
	btd_shaper_t st_next;
	logic [5:0]  period_half;
	logic [5:0]  high_half;
	logic [5:0]  cnt_inc;

	// Period and high time per select code, in half cycles
	always_comb begin
		period_half = (BTD_PERIOD_BASE + 6'(BTD_PERIOD_STEP * freq_sel[1:0])) << freq_sel[2];
		if (freq_sel[1] == 1'b0) begin
			high_half = 6'(BTD_HIGH_BASE_LO - {3'h0, duty_sel}) << freq_sel[2];
		end else begin
			high_half = 6'(BTD_HIGH_BASE_HI - {3'h0, duty_sel}) << freq_sel[2];
		end
	end

	// Free running counter, high while count below high time
	always_comb begin
		st_next = st_reg;
		cnt_inc = st_reg.cnt + 6'h01;
		if (!run) begin
			st_next.cnt   = 6'h00;
			st_next.level = 1'b0;
		end else if (half_tick) begin
			if (cnt_inc >= period_half) begin
				st_next.cnt = 6'h00;
			end else begin
				st_next.cnt = cnt_inc;
			end
			st_next.level = (st_next.cnt < high_half);
		end
	end

	// Register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tone_level = st_reg.level;
	assign half_count = st_reg.cnt;

endmodule

/* btd_top.sv */
// Notes on behaviour
// - The tone generator runs only while the clock-gate bit is 1 and is held cleared and silent otherwise.
// - The divider steps on the low-speed oscillator and a 256 Hz burst tick is that clock over 128.
// - With output enable at 1 the tone drives the shared pin and port direction and data are ignored.
// - With output enable at 0 the shared pin is a plain port under its own direction and data.
// - The tone runs freely and is not aligned to enable writes, so a short pulse may appear.
// - The tone divides the 32.768 kHz oscillator by one of eight ratios from a 3-bit select.
// - Codes 0 to 7 give 4096.0, 3276.8, 2730.7, 2340.6, 2048.0, 1638.4, 1365.3, 1170.3 Hz.
// - A 3-bit duty select gives eight levels, code 0 widest and loudest, code 7 narrowest.
// - High fraction is (8 - duty)/16 or (8 - duty)/20 for the two shortest period groups.
// - High fraction is (12 - duty)/24 or (12 - duty)/28 for the two longest period groups.
// - Duty is high time over the sum of high and low time in one tone period.
// - While the envelope override is active its level replaces the duty select field.
// - Reset clears clock gate, output enable, frequency select and duty select to 0.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps

module btd_top
	import btd_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Oscillator and envelope override
	input  wire logic        low_speed_osc_clock,
	input  wire logic        duty_override_en,
	input  wire logic [2:0]  duty_override_level,
	// Shared port pin
	input  wire logic        shared_port_pin_in,
	output logic             shared_port_pin_out,
	output logic             shared_port_pin_oe,
	// Burst timing
	output logic             burst_tick_256
);

	// ==========================================================
	// State of the block
	typedef struct packed {
		logic        tone_clock_gate;
		logic        tone_output_enable;
		logic [2:0]  tone_freq_select;
		logic [2:0]  tone_duty_select;
		logic        port_data;
		logic        shared_pin_direction_ctrl;
		logic        osc_prev;
		logic [6:0]  burst_cnt;
		logic        burst_tick;
		logic        pin_out;
		logic        pin_oe;
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} btd_state_t;

	btd_state_t st_reg;
	btd_state_t st_next;

	// Internal nets
	logic        osc_rise;
	logic        half_tick;
	logic [2:0]  duty_eff;
	logic        tone_level;
	logic [5:0]  half_count;
	logic        acc_start;
	logic        acc_done;
	logic        addr_ok;
	logic [31:0] rd_word;

	// ==========================================================
	// Oscillator edges: both edges are half-cycle ticks
	always_comb begin
		osc_rise  = low_speed_osc_clock & ~st_reg.osc_prev;
		half_tick = (low_speed_osc_clock ^ st_reg.osc_prev) & st_reg.tone_clock_gate;
	end

	// Envelope level replaces the duty field while active
	always_comb begin
		if (duty_override_en) begin
			duty_eff = duty_override_level;
		end else begin
			duty_eff = st_reg.tone_duty_select;
		end
	end

	// ==========================================================
	// Tone divider and duty shaper
	btd_tone_shaper u_shaper (
		.pclk       (pclk),
		.presetn    (presetn),
		.run        (st_reg.tone_clock_gate),
		.half_tick  (half_tick),
		.freq_sel   (st_reg.tone_freq_select),
		.duty_sel   (duty_eff),
		.tone_level (tone_level),
		.half_count (half_count)
	);

	// ==========================================================
	// APB decode
	always_comb begin
		acc_start = psel & penable & ~st_reg.ack;
		acc_done  = psel & penable & st_reg.ack;
		addr_ok   = (paddr == BTD_CTRL_OFS) || (paddr == BTD_FREQ_OFS)
			|| (paddr == BTD_DUTY_OFS) || (paddr == BTD_PORT_OFS)
			|| (paddr == BTD_STATUS_OFS);
	end

	// Read multiplexer
	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr)
			BTD_CTRL_OFS: begin
				rd_word[BTD_CTRL_GATE_BIT] = st_reg.tone_clock_gate;
				rd_word[BTD_CTRL_OE_BIT]   = st_reg.tone_output_enable;
			end
			BTD_FREQ_OFS: begin
				rd_word[2:0] = st_reg.tone_freq_select;
			end
			BTD_DUTY_OFS: begin
				rd_word[2:0] = st_reg.tone_duty_select;
			end
			BTD_PORT_OFS: begin
				rd_word[BTD_PORT_DATA_BIT] = st_reg.port_data;
				rd_word[BTD_PORT_DIR_BIT]  = st_reg.shared_pin_direction_ctrl;
			end
			BTD_STATUS_OFS: begin
				rd_word[BTD_STAT_TONE_BIT] = tone_level;
				rd_word[BTD_STAT_PIN_BIT]  = shared_port_pin_in;
				rd_word[BTD_STAT_OVR_BIT]  = duty_override_en;
				rd_word[BTD_STAT_DUTY_LSB +: 3] = duty_eff;
				rd_word[BTD_STAT_CNT_LSB +: 6]  = half_count;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;

		// Bus handshake: answer one cycle into the access phase
		st_next.ack = acc_start;
		if (acc_start) begin
			st_next.err   = ~addr_ok;
			st_next.rdata = (pwrite || !addr_ok) ? 32'h0000_0000 : rd_word;
		end else begin
			st_next.err   = 1'b0;
			st_next.rdata = 32'h0000_0000;
		end

		// Register writes land on the completing edge
		if (acc_done && pwrite && pstrb[0]) begin
			case (paddr)
				BTD_CTRL_OFS: begin
					st_next.tone_clock_gate    = pwdata[BTD_CTRL_GATE_BIT];
					st_next.tone_output_enable = pwdata[BTD_CTRL_OE_BIT];
				end
				BTD_FREQ_OFS: begin
					st_next.tone_freq_select = pwdata[2:0];
				end
				BTD_DUTY_OFS: begin
					st_next.tone_duty_select = pwdata[2:0];
				end
				BTD_PORT_OFS: begin
					st_next.port_data                 = pwdata[BTD_PORT_DATA_BIT];
					st_next.shared_pin_direction_ctrl = pwdata[BTD_PORT_DIR_BIT];
				end
				default: begin
					st_next.port_data = st_reg.port_data;
				end
			endcase
		end

		// Oscillator sample for edge detection
		st_next.osc_prev = low_speed_osc_clock;

		// 256 Hz burst tick from rising oscillator edges
		st_next.burst_tick = 1'b0;
		if (!st_reg.tone_clock_gate) begin
			st_next.burst_cnt = 7'h00;
		end else if (osc_rise) begin
			if (st_reg.burst_cnt == BTD_BURST_LAST) begin
				st_next.burst_cnt  = 7'h00;
				st_next.burst_tick = 1'b1;
			end else begin
				st_next.burst_cnt = st_reg.burst_cnt + 7'h01;
			end
		end

		// Shared pin: tone overrides port settings, no alignment to enable
		if (st_reg.tone_output_enable) begin
			st_next.pin_out = tone_level;
			st_next.pin_oe  = 1'b1;
		end else begin
			st_next.pin_out = st_reg.port_data;
			st_next.pin_oe  = st_reg.shared_pin_direction_ctrl;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg                           <= '0;
			st_reg.tone_clock_gate           <= BTD_GATE_RST;
			st_reg.tone_output_enable        <= BTD_OE_RST;
			st_reg.tone_freq_select          <= BTD_FREQ_RST;
			st_reg.tone_duty_select          <= BTD_DUTY_RST;
			st_reg.port_data                 <= BTD_PORT_DATA_RST;
			st_reg.shared_pin_direction_ctrl <= BTD_PORT_DIR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs, all from flops
	assign prdata              = st_reg.rdata;
	assign pready              = st_reg.ack;
	assign pslverr             = st_reg.err;
	assign shared_port_pin_out = st_reg.pin_out;
	assign shared_port_pin_oe  = st_reg.pin_oe;
	assign burst_tick_256      = st_reg.burst_tick;

endmodule

/* btd_top_monitor.sv */
`timescale 1ns/100ps
// ==========================================================
// Bus and pin checks
module btd_top_monitor
	import btd_pkg::*;
(
	// Clock, reset and bus
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// Pin and tick
	input logic        shared_port_pin_oe,
	input logic        burst_tick_256
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answer timing
	property p_rdy_next; psel && penable && !pready |=> pready; endproperty
	a_rdy_next: assert property (p_rdy_next) else $error("answer late");
	property p_rdy_once; pready |=> !pready; endproperty
	a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
	property p_rdy_cause; pready |-> $past(psel && penable); endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready unasked");
	// Address decode and read data
	property p_err_bad;
		psel && penable && !pready && (paddr > 8'h10 || paddr[1:0] != 2'h0) |=> pslverr;
	endproperty
	a_err_bad: assert property (p_err_bad) else $error("no error on hole");
	property p_err_good;
		psel && penable && !pready && paddr <= 8'h10 && paddr[1:0] == 2'h0 |=> !pslverr;
	endproperty
	a_err_good: assert property (p_err_good) else $error("error on register");
	property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("data outside answer");
	// Tick spacing, reset state, pin drive cause
	property p_tick_gap; burst_tick_256 |=> !burst_tick_256 [*8]; endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick too close");
	property p_reset_quiet; $rose(presetn) |-> !shared_port_pin_oe && !pready; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("active at reset");
	property p_oe_cause;
		$changed(shared_port_pin_oe) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin drive moved");
	c_err: cover property (pready && pslverr);
	c_tick: cover property (burst_tick_256);
	c_oe: cover property ($rose(shared_port_pin_oe));
endmodule

bind btd_top btd_top_monitor i_btd_top_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .shared_port_pin_oe(shared_port_pin_oe),
	.burst_tick_256(burst_tick_256));

/* btd_buzzer_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Buzzer side of the shared pin
module btd_buzzer_model (
	// Pin from the block
	input  logic pin_out,
	input  logic pin_oe,
	// Outside level when the block lets go
	input  logic ext_level,
	output logic pin_in
);
	// Block drive wins, else the outside level
	assign pin_in = pin_oe ? pin_out : ext_level;
endmodule

/* testbench.sv */
`timescale 1ns/100ps
// ==========================================================
// Bench
module testbench
	import btd_pkg::*;
;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata, r;
	logic        pready, pslverr, se, osc = 0, ov_en = 0, ext = 0, pin_in, pin_out, pin_oe, tick;
	logic [2:0]  ov_lvl = 0;
	logic [1:0]  dv = 0;
	int          err_count = 0, samples_checked = 0, hi, per, n, m;
	// Clock and oscillator, half tick every 4 pclk
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		dv <= dv + 2'h1;
		if (dv == 2'h3) osc <= ~osc;
	end
	btd_top i_btd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .low_speed_osc_clock(osc),
		.duty_override_en(ov_en), .duty_override_level(ov_lvl), .shared_port_pin_in(pin_in),
		.shared_port_pin_out(pin_out), .shared_port_pin_oe(pin_oe), .burst_tick_256(tick));
	btd_buzzer_model i_btd_buzzer_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext), .pin_in(pin_in));
	// Compare and closing
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin err_count++; final_report(); end
		r = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Bounded wait for a pin level, cycles in n
	task wt(input logic v);
		for (n = 0; pin_out !== v; n++) begin
			if (n > 600) begin err_count++; final_report(); end
			@(posedge pclk);
		end
	endtask
	task meas;
		wt(0); wt(1); wt(0);
		hi = n;
		wt(1);
		per = hi + n;
	endtask
	// Scenarios
	task t_reset;
		for (int a = 0; a < 16; a += 4) begin
			apb(0, 8'(a), 0);
			chk(r, 0);
		end
		$display("reset values done");
	endtask
	task t_gate_off;
		m = 0;
		for (int i = 0; i < 1100; i++) begin
			@(posedge pclk);
			if (tick === 1'b1) m++;
		end
		chk(m, 0);
		apb(0, BTD_STATUS_OFS, 0);
		chk(r & 32'h3F01, 0);
		$display("gate off done");
	endtask
	task t_tone;
		apb(1, BTD_CTRL_OFS, 3);
		for (int f = 0; f < 8; f++) begin
			apb(1, BTD_FREQ_OFS, f);
			apb(1, BTD_DUTY_OFS, f);
			meas; meas;
			m = f > 3 ? 8 : 4;
			chk(per, (16 + 4 * (f & 3)) * m);
			chk(hi, (((f & 2) ? 12 : 8) - f) * m);
		end
		$display("tone table done");
	endtask
	task t_override;
		apb(1, BTD_FREQ_OFS, 0);
		apb(1, BTD_DUTY_OFS, 0);
		ov_en <= 1;
		ov_lvl <= 7;
		meas; meas;
		chk(hi, 4);
		apb(0, BTD_STATUS_OFS, 0);
		chk((r >> 2) & 32'h1D, 32'h1D);
		ov_en <= 0;
		$display("override done");
	endtask
	task t_port;
		apb(1, BTD_PORT_OFS, 3);
		// First period may still carry the old duty
		meas; meas;
		chk(pin_oe, 1);
		chk(per, 64);
		apb(1, BTD_CTRL_OFS, 1);
		// Pin flop follows the register one cycle later
		@(posedge pclk);
		chk({pin_oe, pin_out}, 2'h3);
		apb(1, BTD_PORT_OFS, 0);
		ext <= 1;
		@(posedge pclk);
		chk({pin_oe, pin_out}, 2'h0);
		apb(0, BTD_STATUS_OFS, 0);
		chk(r[1], 1);
		$display("port done");
	endtask
	task t_tick;
		for (n = 0; tick !== 1'b1; n++) begin
			if (n > 1500) begin err_count++; final_report(); end
			@(posedge pclk);
		end
		@(posedge pclk);
		for (m = 1; tick !== 1'b1 && m < 1500; m++) @(posedge pclk);
		chk(m, BTD_BURST_DIV * 8);
		apb(0, 8'h14, 0);
		chk(se, 1);
		chk(r, 0);
		$display("tick and hole done");
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset;
		t_gate_off;
		t_tone;
		t_override;
		t_port;
		t_tick;
		final_report();
	end
endmodule
